// *** hdl/irq_ctrl_pkg.sv ***
/*
  Package for the two-level interrupt controller: register offsets,
  field positions, reset values, vector addresses and the struct that
  carries the peripheral event strobes.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package irq_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_GLOBAL   = 8'h00;  // global_interrupt_control
  localparam logic [7:0] OFF_EDGE     = 8'h04;  // edge_and_priority_control
  localparam logic [7:0] OFF_EXTPIN   = 8'h08;  // external_pin_interrupt_control
  localparam logic [7:0] OFF_PERIPH   = 8'h0C;  // peripheral_flags_one
  localparam logic [7:0] OFF_PERIPH_EN = 8'h10; // peripheral enables
  localparam logic [7:0] OFF_PERIPH_PR = 8'h14; // peripheral priorities
  localparam logic [7:0] OFF_MODE     = 8'h18;  // priority mode enable
  localparam logic [7:0] OFF_STATUS   = 8'h1C;  // request and high-service status
  localparam logic [7:0] OFF_ACK      = 8'h20;  // core acceptance / return

  // Global register fields
  localparam int GLB_GIE  = 7;
  localparam int GLB_PEIE = 6;
  localparam int GLB_T0E  = 5;
  localparam int GLB_I0E  = 4;
  localparam int GLB_PCE  = 3;
  localparam int GLB_T0F  = 2;
  localparam int GLB_I0F  = 1;
  localparam int GLB_PCF  = 0;

  // Edge and priority fields
  localparam int EDG_PU   = 7;
  localparam int EDG_E0   = 6;
  localparam int EDG_E1   = 5;
  localparam int EDG_E2   = 4;
  localparam int EDG_T0P  = 2;
  localparam int EDG_PCP  = 0;
  localparam logic [7:0] EDG_MASK = 8'hF5;

  // External pin register fields
  localparam int EXT_I2P  = 7;
  localparam int EXT_I1P  = 6;
  localparam int EXT_I2E  = 4;
  localparam int EXT_I1E  = 3;
  localparam int EXT_I2F  = 1;
  localparam int EXT_I1F  = 0;
  localparam logic [7:0] EXT_MASK = 8'hDB;

  // Peripheral flag fields
  localparam int PF_PSP = 7;
  localparam int PF_AD  = 6;
  localparam int PF_RX  = 5;
  localparam int PF_TX  = 4;
  localparam int PF_SSP = 3;
  localparam int PF_CCP = 2;
  localparam int PF_T2  = 1;
  localparam int PF_T1  = 0;
  localparam logic [7:0] PF_SW_MASK = 8'hCF;  // software-clearable bits

  // Reset values
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_EDGE   = 8'hF5;
  localparam logic [7:0] RST_EXTPIN = 8'hC0;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] RST_PEN    = 8'h00;
  localparam logic [7:0] RST_PPR    = 8'hFF;

  // Acknowledge register fields
  localparam int ACK_TAKE = 0;
  localparam int ACK_RET  = 1;

  // Vector addresses
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;

  // Peripheral event strobes, one cycle each
  typedef struct packed {
    logic parallel_slave;   // port read or write done
    logic conversion_done;  // converter finished
    logic sync_serial_done; // sync serial transfer done
    logic capture_compare;  // capture or compare event
    logic timer_two_match;  // timer two hit its period
    logic timer_one_ovf;    // timer one overflow
    logic timer_zero_ovf;   // timer zero overflow
  } periph_events_s;

  // Serial buffer levels
  typedef struct packed {
    logic receive_full;     // receive buffer holds data
    logic transmit_empty;   // transmit buffer has room
  } serial_levels_s;

endpackage

// *** hdl/two_level_interrupt_control.sv ***
/*
  Two-level interrupt controller with APB register access.
  Holds global control, edge and priority, external pin and peripheral
  flag registers, detects pin edges and port changes, and raises a high
  or low level request with its vector to the processor core.
  Assumes pins are asynchronous, event strobes are synchronous one-cycle
  pulses on pclk, and the core reports acceptance and return on the accept and return_done ports.
*/
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module two_level_interrupt_control #(
  parameter bit HAS_PARALLEL_SLAVE = 1'b1  // Clear for the small package
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic                                pready,
  output logic [31:0]                         prdata,
  output logic                                pslverr,
  input  wire logic [2:0]                     ext_pins,
  input  wire logic [3:0]                     upper_port_b_pins,
  input  wire logic [7:0]                     port_b_latch,
  input  wire logic                           port_b_read,
  input  wire irq_ctrl_pkg::periph_events_s   events,
  input  wire irq_ctrl_pkg::serial_levels_s   serial,
  input  wire logic                           accept,
  input  wire logic                           return_done,
  output logic [7:0]                          pullup_enable,
  output logic                                request_high,
  output logic                                request_low,
  output logic                                request_any,
  output logic [15:0]                         vector
);

  // Register state
  logic [7:0]  global_interrupt_control;        // enables and core flags
  logic [7:0]  edge_and_priority_control;       // edges and priorities
  logic [7:0]  external_pin_interrupt_control;  // pin one and two
  logic [7:0]  peripheral_flags_one;            // sticky peripheral flags
  logic [7:0]  periph_enable;                   // peripheral enables
  logic [7:0]  periph_priority;                 // peripheral priorities
  logic        priority_mode_enable;            // two-level mode
  logic        in_high_service;                 // high routine running

  // Synchronisers: first stage read only by second stage
  logic [2:0]  ext_meta;
  logic [2:0]  ext_sync;
  logic [2:0]  ext_prev;
  logic [3:0]  port_meta;
  logic [3:0]  port_sync;
  logic [3:0]  port_snap;  // value captured at last port read

  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wbyte;
  logic        mapped;
  logic [7:0]  rd_mux;

  // Event detection
  logic [2:0]  ext_edge;
  logic        port_mismatch;
  logic [7:0]  periph_view;

  // Request logic
  logic        high_pending;
  logic        low_pending;
  logic        next_req_high;
  logic        next_req_low;

  // Edge test for one pin against its select bit
  function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
    edge_hit = rising ? (!prev && now) : (prev && !now);
  endfunction

  // Write strobe test for one register offset
  function automatic logic hit(input logic [7:0] off);
    hit = wr_en && (paddr == off);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta  <= 3'h0;
      ext_sync  <= 3'h0;
      ext_prev  <= 3'h0;
      port_meta <= 4'h0;
      port_sync <= 4'h0;
    end else begin
      ext_meta  <= ext_pins;
      ext_sync  <= ext_meta;
      ext_prev  <= ext_sync;
      port_meta <= upper_port_b_pins;
      port_sync <= port_meta;
    end
  end

  // Pin edges per selected polarity
  always_comb begin
    ext_edge[0] = edge_hit(ext_prev[0], ext_sync[0],
                           edge_and_priority_control[irq_ctrl_pkg::EDG_E0]);
    ext_edge[1] = edge_hit(ext_prev[1], ext_sync[1],
                           edge_and_priority_control[irq_ctrl_pkg::EDG_E1]);
    ext_edge[2] = edge_hit(ext_prev[2], ext_sync[2],
                           edge_and_priority_control[irq_ctrl_pkg::EDG_E2]);
  end

  // Snapshot of the upper port taken on every port read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_snap <= 4'h0;
    end else if (port_b_read) begin
      port_snap <= port_sync;
    end
  end

  // Mismatch persists until software reads the port
  assign port_mismatch = (port_sync != port_snap);

  // Global control: enables by write, flags by events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_interrupt_control <= irq_ctrl_pkg::RST_GLOBAL;
    end else begin
      if (hit(irq_ctrl_pkg::OFF_GLOBAL)) begin
        global_interrupt_control <= wbyte;
      end
      // Acceptance clears the level's enable
      if (accept && request_any) begin
        if (!priority_mode_enable || request_high) begin
          global_interrupt_control[irq_ctrl_pkg::GLB_GIE] <= 1'b0;
        end else begin
          global_interrupt_control[irq_ctrl_pkg::GLB_PEIE] <= 1'b0;
        end
      end
      // Return from service sets the enable back
      if (return_done) begin
        if (!priority_mode_enable || in_high_service) begin
          global_interrupt_control[irq_ctrl_pkg::GLB_GIE] <= 1'b1;
        end else begin
          global_interrupt_control[irq_ctrl_pkg::GLB_PEIE] <= 1'b1;
        end
      end
      // Sets last so an event beats a same-cycle clear
      if (events.timer_zero_ovf) begin
        global_interrupt_control[irq_ctrl_pkg::GLB_T0F] <= 1'b1;
      end
      if (ext_edge[0]) begin
        global_interrupt_control[irq_ctrl_pkg::GLB_I0F] <= 1'b1;
      end
      if (port_mismatch) begin
        global_interrupt_control[irq_ctrl_pkg::GLB_PCF] <= 1'b1;
      end
    end
  end

  // Edge and priority register; unimplemented bits held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_and_priority_control <= irq_ctrl_pkg::RST_EDGE;
    end else if (hit(irq_ctrl_pkg::OFF_EDGE)) begin
      edge_and_priority_control <= wbyte & irq_ctrl_pkg::EDG_MASK;
    end
  end

  // External pin register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_pin_interrupt_control <= irq_ctrl_pkg::RST_EXTPIN;
    end else begin
      if (hit(irq_ctrl_pkg::OFF_EXTPIN)) begin
        external_pin_interrupt_control <= wbyte & irq_ctrl_pkg::EXT_MASK;
      end
      if (ext_edge[1]) begin
        external_pin_interrupt_control[irq_ctrl_pkg::EXT_I1F] <= 1'b1;
      end
      if (ext_edge[2]) begin
        external_pin_interrupt_control[irq_ctrl_pkg::EXT_I2F] <= 1'b1;
      end
    end
  end

  // Peripheral flags: sticky bits written by software, sets win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_flags_one <= irq_ctrl_pkg::RST_PERIPH;
    end else begin
      if (hit(irq_ctrl_pkg::OFF_PERIPH)) begin
        peripheral_flags_one <= wbyte & irq_ctrl_pkg::PF_SW_MASK;
      end
      if (events.parallel_slave && HAS_PARALLEL_SLAVE) begin
        peripheral_flags_one[irq_ctrl_pkg::PF_PSP] <= 1'b1;
      end
      if (events.conversion_done) begin
        peripheral_flags_one[irq_ctrl_pkg::PF_AD] <= 1'b1;
      end
      if (events.sync_serial_done) begin
        peripheral_flags_one[irq_ctrl_pkg::PF_SSP] <= 1'b1;
      end
      if (events.capture_compare) begin
        peripheral_flags_one[irq_ctrl_pkg::PF_CCP] <= 1'b1;
      end
      if (events.timer_two_match) begin
        peripheral_flags_one[irq_ctrl_pkg::PF_T2] <= 1'b1;
      end
      if (events.timer_one_ovf) begin
        peripheral_flags_one[irq_ctrl_pkg::PF_T1] <= 1'b1;
      end
    end
  end

  // Serial flags are live levels from the serial block
  always_comb begin
    periph_view = peripheral_flags_one;
    periph_view[irq_ctrl_pkg::PF_RX] = serial.receive_full;
    periph_view[irq_ctrl_pkg::PF_TX] = serial.transmit_empty;
  end

  // Peripheral enable, priority and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_enable        <= irq_ctrl_pkg::RST_PEN;
      periph_priority      <= irq_ctrl_pkg::RST_PPR;
      priority_mode_enable <= 1'b0;
    end else begin
      if (hit(irq_ctrl_pkg::OFF_PERIPH_EN)) begin
        periph_enable <= wbyte;
      end
      if (hit(irq_ctrl_pkg::OFF_PERIPH_PR)) begin
        periph_priority <= wbyte;
      end
      if (hit(irq_ctrl_pkg::OFF_MODE)) begin
        priority_mode_enable <= pwdata[0];
      end
    end
  end

  // Pending sources split by priority
  always_comb begin
    logic [7:0] core_act;
    logic [7:0] core_pri;
    logic [7:0] per_act;
    core_act = '0;
    core_pri = '0;
    per_act  = periph_view & periph_enable;
    if (!HAS_PARALLEL_SLAVE) begin
      per_act[irq_ctrl_pkg::PF_PSP] = 1'b0;
    end
    core_act[0] = global_interrupt_control[irq_ctrl_pkg::GLB_T0F]
                & global_interrupt_control[irq_ctrl_pkg::GLB_T0E];
    core_act[1] = global_interrupt_control[irq_ctrl_pkg::GLB_I0F]
                & global_interrupt_control[irq_ctrl_pkg::GLB_I0E];
    core_act[2] = global_interrupt_control[irq_ctrl_pkg::GLB_PCF]
                & global_interrupt_control[irq_ctrl_pkg::GLB_PCE];
    core_act[3] = external_pin_interrupt_control[irq_ctrl_pkg::EXT_I1F]
                & external_pin_interrupt_control[irq_ctrl_pkg::EXT_I1E];
    core_act[4] = external_pin_interrupt_control[irq_ctrl_pkg::EXT_I2F]
                & external_pin_interrupt_control[irq_ctrl_pkg::EXT_I2E];
    core_pri[0] = edge_and_priority_control[irq_ctrl_pkg::EDG_T0P];
    core_pri[1] = 1'b1;  // pin zero is always high priority
    core_pri[2] = edge_and_priority_control[irq_ctrl_pkg::EDG_PCP];
    core_pri[3] = external_pin_interrupt_control[irq_ctrl_pkg::EXT_I1P];
    core_pri[4] = external_pin_interrupt_control[irq_ctrl_pkg::EXT_I2P];
    if (priority_mode_enable) begin
      high_pending = |(core_act & core_pri) | |(per_act & periph_priority);
      low_pending  = |(core_act & ~core_pri) | |(per_act & ~periph_priority);
    end else begin
      // Compatibility: core sources plus gated peripherals, one level
      high_pending = |core_act
                   | (|per_act & global_interrupt_control[irq_ctrl_pkg::GLB_PEIE]);
      low_pending  = 1'b0;
    end
  end

  // Request qualification by the global bits
  always_comb begin
    next_req_high = high_pending && global_interrupt_control[irq_ctrl_pkg::GLB_GIE];
    // Low level needs both bits and no high routine running
    next_req_low  = priority_mode_enable && low_pending && !next_req_high
                  && global_interrupt_control[irq_ctrl_pkg::GLB_GIE]
                  && global_interrupt_control[irq_ctrl_pkg::GLB_PEIE]
                  && !in_high_service;
  end

  // Registered request outputs, two cycles from a synced pin edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_high <= 1'b0;
      request_low  <= 1'b0;
      request_any  <= 1'b0;
      vector       <= irq_ctrl_pkg::VEC_HIGH;
    end else begin
      request_high <= next_req_high;
      request_low  <= next_req_low;
      request_any  <= next_req_high || next_req_low;
      vector       <= next_req_low ? irq_ctrl_pkg::VEC_LOW : irq_ctrl_pkg::VEC_HIGH;
    end
  end

  // High service tracking, lets high preempt low but not the reverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_high_service <= 1'b0;
    end else if (accept && request_high) begin
      in_high_service <= 1'b1;
    end else if (return_done) begin
      in_high_service <= 1'b0;
    end
  end

  // Pull-ups follow latch unless globally disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_enable <= 8'h00;
    end else begin
      pullup_enable <= edge_and_priority_control[irq_ctrl_pkg::EDG_PU]
                     ? 8'h00 : port_b_latch;
    end
  end

  // Address decode for reads
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    unique case (paddr)
      irq_ctrl_pkg::OFF_GLOBAL:    rd_mux = global_interrupt_control;
      irq_ctrl_pkg::OFF_EDGE:      rd_mux = edge_and_priority_control;
      irq_ctrl_pkg::OFF_EXTPIN:    rd_mux = external_pin_interrupt_control;
      irq_ctrl_pkg::OFF_PERIPH:    rd_mux = periph_view;
      irq_ctrl_pkg::OFF_PERIPH_EN: rd_mux = periph_enable;
      irq_ctrl_pkg::OFF_PERIPH_PR: rd_mux = periph_priority;
      irq_ctrl_pkg::OFF_MODE:      rd_mux = {7'h00, priority_mode_enable};
      irq_ctrl_pkg::OFF_STATUS:    rd_mux = {5'h00, in_high_service, request_low, request_high};
      irq_ctrl_pkg::OFF_ACK:       rd_mux = 8'h00;
      default:                     mapped = 1'b0;
    endcase
  end

  // APB answer: data captured in setup, ready in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

endmodule

`default_nettype wire

// *** sim/core_model.sv ***
/* Processor core model: takes requests and returns from service.
   Assumes the bench sets take_en, lag and ret_cmd on rising edges. */
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       request_any,
  input  wire logic       take_en,
  input  wire logic [2:0] lag,
  input  wire logic       ret_cmd,
  output logic            accept,
  output logic            return_done
);
  logic [2:0] wait_cnt;  // Cycles the request has stood while take_en is set
  logic       busy;      // Taken, until the request falls
  // One acceptance per request, so a lingering level is not taken twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept   <= 1'b0;
      wait_cnt <= 3'h0;
      busy     <= 1'b0;
    end else begin
      accept <= 1'b0;
      if (!request_any) begin
        wait_cnt <= 3'h0;
        busy     <= 1'b0;
      end else if (take_en && !busy) begin
        if (wait_cnt >= lag) begin
          accept <= 1'b1;
          busy   <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
  // Return only on command, so software can inspect the cleared enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_done <= 1'b0;
    end else begin
      return_done <= ret_cmd;
    end
  end
endmodule
`default_nettype wire

// *** sim/irq_ctrl_props.sv ***
/* Port checker for the interrupt controller.
   Assumes the bind below; sees only top-level ports. */
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_props (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [7:0]                   paddr,
  input wire logic                         pready,
  input wire logic [31:0]                  prdata,
  input wire logic                         pslverr,
  input wire logic [7:0]                   port_b_latch,
  input wire irq_ctrl_pkg::serial_levels_s serial,
  input wire logic                         accept,
  input wire logic [7:0]                   pullup_enable,
  input wire logic                         request_high,
  input wire logic                         request_low,
  input wire logic                         request_any,
  input wire logic [15:0]                  vector
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_cyc;  // Access cycle of a read
  assign rd_cyc = pready && psel && !pwrite;
  // Zero wait states
  pready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  slverr_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access cycle");
  high_vector_a: assert property (request_high |-> vector == 16'h0008)
    else $error("high request with wrong vector");
  any_req_a: assert property (request_any == (request_high || request_low))
    else $error("request_any disagrees with levels");
  edge_rsvd_a: assert property (
    rd_cyc && paddr == irq_ctrl_pkg::OFF_EDGE |-> (prdata & 32'h0A) == 32'h0)
    else $error("edge register reserved bit set");
  pin_rsvd_a: assert property (
    rd_cyc && paddr == irq_ctrl_pkg::OFF_EXTPIN |-> (prdata & 32'h24) == 32'h0)
    else $error("pin register reserved bit set");
  serial_flag_a: assert property (
    rd_cyc && paddr == irq_ctrl_pkg::OFF_PERIPH |-> prdata[5:4] == $past(serial))
    else $error("serial flags do not follow levels");
  pullup_a: assert property ((pullup_enable & ~$past(port_b_latch)) == 8'h00)
    else $error("pull-up on where latch is low");
  accept_drop_a: assert property (
    accept && request_high && !request_low |-> ##[1:3] !request_any)
    else $error("request stands after acceptance");
endmodule
bind two_level_interrupt_control irq_ctrl_props i_irq_ctrl_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
  .pslverr, .port_b_latch, .serial, .accept, .pullup_enable,
  .request_high, .request_low, .request_any, .vector);
`default_nettype wire

// *** sim/two_level_interrupt_control_test.sv ***
/* Self-checking bench for the interrupt controller.
   Assumes the core model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_control_test;
  logic        pclk, presetn, psel, penable, pwrite, port_b_read, se;
  logic        take_en, ret_cmd, pready, pslverr, accept, return_done;
  logic        request_high, request_low, request_any;
  logic [7:0]  paddr, port_b_latch, rv, pullup_enable;
  logic [31:0] pwdata, prdata;
  logic [15:0] vector;
  logic [2:0]  ext_pins, lag;
  logic [3:0]  upb;
  irq_ctrl_pkg::periph_events_s events;
  irq_ctrl_pkg::serial_levels_s serial;
  int          bad_count, check_count;
  // Flag bit for each peripheral event field except timer_zero_ovf
  localparam logic [7:0] PMAP [1:6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80};
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  two_level_interrupt_control i_two_level_interrupt_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .ext_pins, .upper_port_b_pins(upb), .port_b_latch,
    .port_b_read, .events, .serial, .accept, .return_done, .pullup_enable,
    .request_high, .request_low, .request_any, .vector);
  core_model i_core_model (.pclk, .presetn, .request_any, .take_en, .lag,
    .ret_cmd, .accept, .return_done);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata[7:0];
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), rv, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One-cycle strobe on one event field
  task automatic pulse(input int i);
    @(posedge pclk);
    events <= irq_ctrl_pkg::periph_events_s'(7'h01 << i);
    @(posedge pclk);
    events <= '0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, port_b_read, take_en, ret_cmd} = '0;
    {paddr, pwdata, ext_pins, upb, lag, events, serial} = '0;
    port_b_latch = 8'hA5;
    tick(8);
    presetn <= 1'b1;
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    rd(irq_ctrl_pkg::OFF_EDGE, 8'hF5);
    rd(irq_ctrl_pkg::OFF_EXTPIN, 8'hC0);
    rd(irq_ctrl_pkg::OFF_PERIPH, 8'h00);
    apb(1'b0, 8'h24, 8'h00);
    chk("unmapped error", se, 1'b1);
    chk("unmapped data", rv, 8'h00);
    chk("pull-ups off", pullup_enable, 8'h00);
    $display("test reset done");
    wr(irq_ctrl_pkg::OFF_EDGE, 8'hFF);
    rd(irq_ctrl_pkg::OFF_EDGE, 8'hF5);
    wr(irq_ctrl_pkg::OFF_EDGE, 8'h00);
    rd(irq_ctrl_pkg::OFF_EDGE, 8'h00);
    chk("pull-ups follow latch", pullup_enable, 8'hA5);
    wr(irq_ctrl_pkg::OFF_EXTPIN, 8'hFC);
    rd(irq_ctrl_pkg::OFF_EXTPIN, 8'hD8);
    $display("test access done");
    // Compatibility mode: flag without enables, then a slow core takes it
    pulse(0);
    tick(4);
    chk("no request", request_any, 1'b0);
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h04);
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'hA4);
    tick(3);
    chk("compat request", request_high, 1'b1);
    chk("compat vector", vector, 16'h0008);
    lag     <= 3'h3;
    take_en <= 1'b1;
    tick(10);
    take_en <= 1'b0;
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h24);
    ret_cmd <= 1'b1;
    tick(1);
    ret_cmd <= 1'b0;
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'hA4);
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'hA0);
    tick(3);
    chk("cleared", request_any, 1'b0);
    $display("test compat done");
    // Priority mode: low level, then high level, prompt core
    wr(irq_ctrl_pkg::OFF_MODE, 8'h01);
    pulse(0);
    tick(4);
    chk("low needs bit 6", request_any, 1'b0);
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'hE4);
    tick(3);
    chk("low request", request_low, 1'b1);
    chk("low vector", vector, 16'h0018);
    wr(irq_ctrl_pkg::OFF_EDGE, 8'h24);
    tick(3);
    chk("high request", request_high, 1'b1);
    chk("high vector", vector, 16'h0008);
    lag     <= 3'h0;
    take_en <= 1'b1;
    tick(6);
    take_en <= 1'b0;
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h64);
    chk("bit 7 off", request_any, 1'b0);
    ret_cmd <= 1'b1;
    tick(1);
    ret_cmd <= 1'b0;
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'hE4);
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    wr(irq_ctrl_pkg::OFF_MODE, 8'h00);
    $display("test priority done");
    // Pins: zero and two falling, one rising
    ext_pins <= 3'b111;
    tick(8);
    rd(irq_ctrl_pkg::OFF_EXTPIN, 8'hD9);
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    ext_pins <= 3'b000;
    tick(8);
    rd(irq_ctrl_pkg::OFF_EXTPIN, 8'hDB);
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h02);
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    $display("test pins done");
    // Port change persists until the port is read
    upb <= 4'h5;
    tick(6);
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h01);
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h01);
    port_b_read <= 1'b1;
    tick(1);
    port_b_read <= 1'b0;
    wr(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    rd(irq_ctrl_pkg::OFF_GLOBAL, 8'h00);
    $display("test port change done");
    // Peripheral flags, each set then cleared
    for (int i = 1; i <= 6; i++) begin
      pulse(i);
      tick(3);
      rd(irq_ctrl_pkg::OFF_PERIPH, PMAP[i]);
      wr(irq_ctrl_pkg::OFF_PERIPH, 8'h00);
    end
    serial <= 2'b11;
    tick(2);
    rd(irq_ctrl_pkg::OFF_PERIPH, 8'h30);
    wr(irq_ctrl_pkg::OFF_PERIPH, 8'h00);
    rd(irq_ctrl_pkg::OFF_PERIPH, 8'h30);
    serial <= 2'b00;
    tick(2);
    rd(irq_ctrl_pkg::OFF_PERIPH, 8'h00);
    $display("test peripherals done");
    finish_test;
  end
  // Watchdog, well past the expected run length
  initial begin
    tick(4000);
    bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
